/* rtl/mcu_irq_controller.sv */
// Purpose: Interrupt controller for a small 8-bit microcontroller core
// Assumes: Core pulses I_IRQ_TAKE when it pushes PC and jumps to O_IRQ_VECTOR
// Notes: Register reads return data one cycle after the address
// How it works
// RULE1: Edge select: off, rising, falling, both
// RULE2: Source event sets its request flag
// RULE3: Jump only when source enable is set
// RULE4: Global enable low blocks every interrupt
// RULE5: Core pushes next PC, loads vector
// RULE6: Return instruction pops saved PC
// RULE7: Accepting an interrupt clears global enable
// RULE8: Blocked requests still latch their flags
// RULE9: Software re-enabling global allows nesting
// RULE10: Full stack holds off all requests
// RULE11: Fixed priority picks one pending source
// RULE12: Any flag set wakes sleep or idle
// RULE13: Dedicated vectors; timers via shared vectors
// RULE14: Primary register bit layout
// RULE15: Secondary register bit layout
// RULE16: First shared-source register bit layout
// RULE17: Second shared-source register bit layout
// RULE18: Unused bits read zero; reset zero
// RULE19: Enabled timer flag sets shared flag
// RULE20: Service clears shared flag only
// RULE21: Service clears dedicated source flag
// RULE22: Wake on flag rising, enable ignored
// RULE23: Priority ext, tb0, tb1, sv0, sv1, eeprom
// RULE24: Hardware set beats same-cycle clear
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.svh"
module mcu_irq_controller #(
  parameter int PC_W = 10,
  parameter logic [PC_W-1:0] VEC_EXT = `IRQ_VEC_EXT,
  parameter logic [PC_W-1:0] VEC_TB0 = `IRQ_VEC_TB0,
  parameter logic [PC_W-1:0] VEC_TB1 = `IRQ_VEC_TB1,
  parameter logic [PC_W-1:0] VEC_SV0 = `IRQ_VEC_SV0,
  parameter logic [PC_W-1:0] VEC_SV1 = `IRQ_VEC_SV1,
  parameter logic [PC_W-1:0] VEC_EE = `IRQ_VEC_EE
) (
  input wire logic I_CLOCK,
  input wire logic I_RSTN,
  input wire logic I_EXT_PIN,
  input wire irq_pkg::reg_req_s I_REG,
  input wire irq_pkg::src_evt_s I_SRC,
  input wire logic I_STACK_FULL,
  input wire logic I_IRQ_TAKE,
  output logic [7:0] O_REG_RDATA,
  output logic O_IRQ_REQ,
  output logic [PC_W-1:0] O_IRQ_VECTOR,
  output irq_pkg::src_e O_IRQ_SRC,
  output logic O_WAKE
);
  import irq_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] edge_q, edge_d; // Edge select register
  logic [7:0] pri_q, pri_d; // Primary control register
  logic [7:0] sec_q, sec_d; // Secondary control register
  logic [7:0] sh0_q, sh0_d; // Standard timer shared-source register
  logic [7:0] sh1_q, sh1_d; // Periodic timer shared-source register
  logic [7:0] rdata_q, rdata_d; // Read data
  logic req_q, req_d; // Request to core
  logic [PC_W-1:0] vec_q, vec_d; // Vector of selected source
  src_e src_q, src_d; // Selected source
  logic wake_q, wake_d; // Wake pulse
  logic ext_evt; // Selected edge seen on the pin
  logic taken; // Core accepted the offered request
  logic [5:0] pend; // Enabled pending sources, priority order
  logic [9:0] flags_new, flags_old; // Every request flag, next and current

  ////////////////////////////////////////////////////////////////////////
  // External pin

  // Synchronise pin and pick the active edge
  irq_edge_detect u_edge (
    .i_clock(I_CLOCK),
    .i_rstn(I_RSTN),
    .i_pin(I_EXT_PIN),
    .i_sel(edge_q[1:0]),
    .o_edge(ext_evt)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register next values

  // Flags: software value or kept value, service clear, then hardware set
  always_comb begin
    logic [7:0] set0, set1, setm0, setm1, clr0, clr1;
    logic [1:0] rise0, rise1;
    set0 = 8'h00;
    set1 = 8'h00;
    setm0 = 8'h00;
    setm1 = 8'h00;
    clr0 = 8'h00;
    clr1 = 8'h00;
    rise0 = 2'h0;
    rise1 = 2'h0;
    taken = I_IRQ_TAKE & req_q;
    // Hardware events latch whatever the enables say
    set0[`IRQ_B_EXT_F] = ext_evt; // RULE2 RULE8
    set0[`IRQ_B_TB0_F] = I_SRC.tbase0; // RULE2 RULE8
    set0[`IRQ_B_TB1_F] = I_SRC.tbase1; // RULE2 RULE8
    set1[`IRQ_B_EE_F] = I_SRC.eeprom_done; // RULE2 RULE8
    setm0[`IRQ_B_CMP_P_F] = I_SRC.std_cmp_p; // RULE2
    setm0[`IRQ_B_CMP_A_F] = I_SRC.std_cmp_a; // RULE2
    setm1[`IRQ_B_CMP_P_F] = I_SRC.per_cmp_p; // RULE2
    setm1[`IRQ_B_CMP_A_F] = I_SRC.per_cmp_a; // RULE2
    // Service clears global enable and the dedicated or shared flag only
    if (taken) begin
      clr0[`IRQ_B_GIE] = 1'b1; // RULE7
      case (src_q)
        SRC_EXT: clr0[`IRQ_B_EXT_F] = 1'b1; // RULE21
        SRC_TB0: clr0[`IRQ_B_TB0_F] = 1'b1; // RULE21
        SRC_TB1: clr0[`IRQ_B_TB1_F] = 1'b1; // RULE21
        SRC_SV0: clr1[`IRQ_B_SV0_F] = 1'b1; // RULE20
        SRC_SV1: clr1[`IRQ_B_SV1_F] = 1'b1; // RULE20
        SRC_EE: clr1[`IRQ_B_EE_F] = 1'b1; // RULE21
        default: clr0 = 8'h00;
      endcase
    end
    // Writes store only implemented bits; unused bits stay zero
    edge_d = ((I_REG.wr && I_REG.addr == `IRQ_IDX_EDGE) ? I_REG.wdata : edge_q)
             & `IRQ_MASK_EDGE; // RULE1 RULE18
    sh0_d = ((((I_REG.wr && I_REG.addr == `IRQ_IDX_SH0) ? I_REG.wdata : sh0_q))
             | setm0) & `IRQ_MASK_SH; // RULE16 RULE24
    sh1_d = ((((I_REG.wr && I_REG.addr == `IRQ_IDX_SH1) ? I_REG.wdata : sh1_q))
             | setm1) & `IRQ_MASK_SH; // RULE17 RULE24
    // A timer flag rising with its enable set raises the shared flag
    rise0 = sh0_d[5:4] & ~sh0_q[5:4] & sh0_d[1:0]; // RULE19
    rise1 = sh1_d[5:4] & ~sh1_q[5:4] & sh1_d[1:0]; // RULE19
    set1[`IRQ_B_SV0_F] = |rise0; // RULE19
    set1[`IRQ_B_SV1_F] = |rise1; // RULE19
    // Software write may set global enable again for nesting
    pri_d = ((((I_REG.wr && I_REG.addr == `IRQ_IDX_PRI) ? I_REG.wdata : pri_q)
             & ~clr0) | set0) & `IRQ_MASK_PRI; // RULE9 RULE14 RULE24
    sec_d = ((((I_REG.wr && I_REG.addr == `IRQ_IDX_SEC) ? I_REG.wdata : sec_q)
             & ~clr1) | set1) & `IRQ_MASK_SEC; // RULE15 RULE24
  end

  ////////////////////////////////////////////////////////////////////////
  // Request selection

  // Gate, prioritise and look up the vector from the next register state
  always_comb begin
    pend[SRC_EXT] = pri_d[`IRQ_B_EXT_F] & pri_d[`IRQ_B_EXT_EN]; // RULE3
    pend[SRC_TB0] = pri_d[`IRQ_B_TB0_F] & pri_d[`IRQ_B_TB0_EN]; // RULE3
    pend[SRC_TB1] = pri_d[`IRQ_B_TB1_F] & pri_d[`IRQ_B_TB1_EN]; // RULE3
    pend[SRC_SV0] = sec_d[`IRQ_B_SV0_F] & sec_d[`IRQ_B_SV0_EN]; // RULE3
    pend[SRC_SV1] = sec_d[`IRQ_B_SV1_F] & sec_d[`IRQ_B_SV1_EN]; // RULE3
    pend[SRC_EE] = sec_d[`IRQ_B_EE_F] & sec_d[`IRQ_B_EE_EN]; // RULE3
    // Global enable and stack space both required
    req_d = pri_d[`IRQ_B_GIE] & ~I_STACK_FULL & (|pend); // RULE4 RULE10
    // Lowest index wins
    src_d = SRC_EE;
    for (int i = 5; i >= 0; i--) begin
      if (pend[i]) begin
        src_d = src_e'(3'(i)); // RULE11 RULE23
      end
    end
    case (src_d)
      SRC_EXT: vec_d = VEC_EXT; // RULE13
      SRC_TB0: vec_d = VEC_TB0; // RULE13
      SRC_TB1: vec_d = VEC_TB1; // RULE13
      SRC_SV0: vec_d = VEC_SV0; // RULE13
      SRC_SV1: vec_d = VEC_SV1; // RULE13
      default: vec_d = VEC_EE; // RULE13
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Wake and read-back

  // Wake on any flag going low to high, enabled or not; each timer flag counts alone
  always_comb begin
    flags_new = {pri_d[6:4], sec_d[7], sec_d[5:4], sh0_d[5:4], sh1_d[5:4]};
    flags_old = {pri_q[6:4], sec_q[7], sec_q[5:4], sh0_q[5:4], sh1_q[5:4]};
    wake_d = |(flags_new & ~flags_old); // RULE12 RULE22
    // Read mux; unmapped indices read zero
    case (I_REG.addr)
      `IRQ_IDX_EDGE: rdata_d = edge_q; // RULE18
      `IRQ_IDX_PRI: rdata_d = pri_q; // RULE14
      `IRQ_IDX_SEC: rdata_d = sec_q; // RULE15
      `IRQ_IDX_SH0: rdata_d = sh0_q; // RULE16
      `IRQ_IDX_SH1: rdata_d = sh1_q; // RULE17
      default: rdata_d = 8'h00; // RULE18
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers

  // All state clears to zero at power-on
  always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      edge_q <= `IRQ_RST_VAL; // RULE18
      pri_q <= `IRQ_RST_VAL; // RULE18
      sec_q <= `IRQ_RST_VAL; // RULE18
      sh0_q <= `IRQ_RST_VAL; // RULE18
      sh1_q <= `IRQ_RST_VAL; // RULE18
      rdata_q <= 8'h00;
      req_q <= 1'b0;
      vec_q <= '0;
      src_q <= SRC_EXT;
      wake_q <= 1'b0;
    end else begin
      edge_q <= edge_d;
      pri_q <= pri_d;
      sec_q <= sec_d;
      sh0_q <= sh0_d;
      sh1_q <= sh1_d;
      rdata_q <= rdata_d;
      req_q <= req_d;
      vec_q <= vec_d;
      src_q <= src_d;
      wake_q <= wake_d;
    end
  end

  // Outputs straight from flops; core pushes PC and pops it on return
  assign O_REG_RDATA = rdata_q;
  assign O_IRQ_REQ = req_q; // RULE5 RULE6
  assign O_IRQ_VECTOR = vec_q; // RULE5
  assign O_IRQ_SRC = src_q;
  assign O_WAKE = wake_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RSTN);

  // Core accepting the offered request
  sequence s_take;
    I_IRQ_TAKE && O_IRQ_REQ;
  endsequence

  // Shared flag serviced with no new standard timer events or writes
  sequence s_take_sv0_quiet;
    s_take and (O_IRQ_SRC == SRC_SV0) and !I_REG.wr and !I_SRC.std_cmp_p and !I_SRC.std_cmp_a;
  endsequence

  a_edge_off: assert property ((edge_q[1:0] == 2'h0) |-> !ext_evt) // RULE1
    else $error("edge event while edge select is off");
  a_flag_set: assert property (I_SRC.eeprom_done |=> sec_q[`IRQ_B_EE_F]) // RULE2
    else $error("eeprom flag not set by its event");
  a_enable_gate: assert property ((O_IRQ_REQ && O_IRQ_SRC == SRC_EXT)
    |-> (pri_q[`IRQ_B_EXT_F] && pri_q[`IRQ_B_EXT_EN])) // RULE3
    else $error("request offered for a disabled source");
  a_global_gate: assert property (O_IRQ_REQ |-> pri_q[`IRQ_B_GIE]) // RULE4
    else $error("request offered with global enable low");
  a_vector_map: assert property ((O_IRQ_REQ && O_IRQ_SRC == SRC_EE)
    |-> (O_IRQ_VECTOR == VEC_EE)) // RULE13
    else $error("wrong vector for eeprom source");
  a_take_gie: assert property (s_take |=> (!pri_q[`IRQ_B_GIE] && !O_IRQ_REQ)) // RULE7
    else $error("global enable not cleared on service");
  a_stack_hold: assert property ($past(I_STACK_FULL) |-> !O_IRQ_REQ) // RULE10
    else $error("request offered while stack full");
  a_priority_pick: assert property ((O_IRQ_REQ && O_IRQ_SRC == SRC_SV1)
    |-> !(pri_q[4] && pri_q[1]) && !(sec_q[4] && sec_q[0])) // RULE11
    else $error("lower priority source chosen");
  a_wake_rise: assert property ((I_SRC.tbase1 && !pri_q[`IRQ_B_TB1_F]) |=> O_WAKE) // RULE22
    else $error("no wake on flag rising");
  a_shared_set: assert property ((I_SRC.std_cmp_p && sh0_q[0] && !sh0_q[4]
    && !I_REG.wr) |=> sec_q[`IRQ_B_SV0_F]) // RULE19
    else $error("shared flag not set by enabled timer flag");
  a_shared_keep: assert property (s_take_sv0_quiet
    |=> (sh0_q[5:4] == $past(sh0_q[5:4], 1))) // RULE20
    else $error("timer flags changed on shared service");
  a_dedicated_clr: assert property ((s_take and (O_IRQ_SRC == SRC_TB0)
    and !I_SRC.tbase0 and !I_REG.wr) |=> !pri_q[`IRQ_B_TB0_F]) // RULE21
    else $error("dedicated flag not cleared on service");
  a_set_wins: assert property ((I_REG.wr && I_REG.addr == `IRQ_IDX_PRI
    && I_SRC.tbase0) |=> pri_q[`IRQ_B_TB0_F]) // RULE24
    else $error("hardware set lost to software write");

  // Offer, priority, vectors, shared service, wake and read-back
  a_ext_latch: assert property (ext_evt |=> pri_q[`IRQ_B_EXT_F]) // RULE2 RULE8
    else $error("external flag not set by its edge");
  a_req_raised: assert property ((pri_q[`IRQ_B_GIE] && pri_q[`IRQ_B_TB0_F] // RULE3 RULE10
    && pri_q[`IRQ_B_TB0_EN] && !$past(I_STACK_FULL)) |-> O_IRQ_REQ)
    else $error("enabled pending source not offered");
  a_tb1_pick: assert property ((O_IRQ_REQ && O_IRQ_SRC == SRC_TB1) // RULE11 RULE23
    |-> !(pri_q[`IRQ_B_EXT_F] && pri_q[`IRQ_B_EXT_EN]) && !(pri_q[`IRQ_B_TB0_F] && pri_q[`IRQ_B_TB0_EN]))
    else $error("time base 1 chosen over a higher source");
  a_sv0_vector: assert property ((O_IRQ_REQ && O_IRQ_SRC == SRC_SV0) // RULE13
    |-> (O_IRQ_VECTOR == VEC_SV0))
    else $error("wrong vector for shared vector 0");
  a_sv1_set: assert property ((I_SRC.per_cmp_a && sh1_q[`IRQ_B_CMP_A_EN] // RULE19
    && !sh1_q[`IRQ_B_CMP_A_F] && !I_REG.wr) |=> sec_q[`IRQ_B_SV1_F])
    else $error("shared flag 1 not set by enabled timer flag");
  a_shared_clr: assert property (s_take_sv0_quiet |=> !sec_q[`IRQ_B_SV0_F]) // RULE20
    else $error("shared flag not cleared on service");
  a_wake_timer: assert property ((I_SRC.per_cmp_a && !sh1_q[`IRQ_B_CMP_A_F]) |=> O_WAKE) // RULE12 RULE22
    else $error("no wake on timer flag rising");
  a_unmapped_zero: assert property ((I_REG.addr > `IRQ_IDX_SH1) |=> (O_REG_RDATA == 8'h00)) // RULE18
    else $error("unmapped register read not zero");

endmodule // mcu_irq_controller
`default_nettype wire

/* rtl/irq_ctrl_regs.svh */
// Purpose: Register map, bit positions, reset values and vector defaults
// Assumes: Registers are reached by index over the core's data-memory port
// Notes: Definitions only
`ifndef IRQ_CTRL_REGS_SVH
`define IRQ_CTRL_REGS_SVH

// Register indices on the data-memory port
`define IRQ_IDX_EDGE 3'h0
`define IRQ_IDX_PRI 3'h1
`define IRQ_IDX_SEC 3'h2
`define IRQ_IDX_SH0 3'h3
`define IRQ_IDX_SH1 3'h4

// Implemented-bit masks; all other bits read as zero
`define IRQ_MASK_EDGE 8'h03
`define IRQ_MASK_PRI 8'h7f
`define IRQ_MASK_SEC 8'hbb
`define IRQ_MASK_SH 8'h33

// Reset value shared by every register
`define IRQ_RST_VAL 8'h00

// Primary control register bits
`define IRQ_B_GIE 0
`define IRQ_B_EXT_EN 1
`define IRQ_B_TB0_EN 2
`define IRQ_B_TB1_EN 3
`define IRQ_B_EXT_F 4
`define IRQ_B_TB0_F 5
`define IRQ_B_TB1_F 6

// Secondary control register bits
`define IRQ_B_SV0_EN 0
`define IRQ_B_EE_EN 1
`define IRQ_B_SV1_EN 3
`define IRQ_B_SV0_F 4
`define IRQ_B_EE_F 5
`define IRQ_B_SV1_F 7

// Shared-source register bits (same layout in both)
`define IRQ_B_CMP_P_EN 0
`define IRQ_B_CMP_A_EN 1
`define IRQ_B_CMP_P_F 4
`define IRQ_B_CMP_A_F 5

// Default vector addresses
`define IRQ_VEC_EXT 10'h004
`define IRQ_VEC_TB0 10'h008
`define IRQ_VEC_TB1 10'h00c
`define IRQ_VEC_SV0 10'h010
`define IRQ_VEC_SV1 10'h014
`define IRQ_VEC_EE 10'h018

`endif

/* rtl/irq_pkg.sv */
// Purpose: Types shared by the interrupt controller files
// Assumes: Nothing beyond the register header
// Notes: Source order equals priority order, highest first
package irq_pkg;

  // Register access from the core, one per cycle
  typedef struct packed {
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // One-cycle event pulses from peripherals on the system clock
  typedef struct packed {
    logic tbase0;
    logic tbase1;
    logic eeprom_done;
    logic std_cmp_p;
    logic std_cmp_a;
    logic per_cmp_p;
    logic per_cmp_a;
  } src_evt_s;

  // Vectored sources in fixed priority order
  typedef enum logic [2:0] {
    SRC_EXT = 3'h0,
    SRC_TB0 = 3'h1,
    SRC_TB1 = 3'h2,
    SRC_SV0 = 3'h3,
    SRC_SV1 = 3'h4,
    SRC_EE = 3'h5
  } src_e;

endpackage

/* rtl/irq_edge_detect.sv */
// Purpose: Synchronise the external request pin and detect selected edges
// Assumes: Pin is asynchronous to the system clock
// Notes: Output is a one-cycle pulse, one to two cycles after the pin moves
`timescale 1ns/1ps
`default_nettype none
module irq_edge_detect (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_pin,
  input wire logic [1:0] i_sel,
  output logic o_edge
);

  logic [2:0] pipe_q; // Two sync stages then previous sample
  logic [2:0] pipe_d;
  logic [2:0] fill_q; // Ones shifted in after reset; top bit marks a full pipe
  logic [2:0] fill_d;

  // Shift the pin through the synchroniser and track the pipe filling
  always_comb begin
    pipe_d = {pipe_q[1:0], i_pin};
    fill_d = {fill_q[1:0], 1'b1};
  end

  // Register the chain
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      pipe_q <= 3'h0;
      fill_q <= 3'h0;
    end else begin
      pipe_q <= pipe_d;
      fill_q <= fill_d;
    end
  end

  // Select 00 off, 01 rising, 10 falling, 11 both
  always_comb begin
    // Held off until the previous sample is real, so a pin idling high gives no edge after reset
    o_edge = fill_q[2] & ((i_sel[0] & pipe_q[1] & ~pipe_q[2]) | // RULE1
             (i_sel[1] & ~pipe_q[1] & pipe_q[2])); // RULE1
  end

endmodule // irq_edge_detect
`default_nettype wire

/* dv/core_model.sv */
// Purpose: Core sequencer and return stack seen from the controller
// Assumes: Take is a one-cycle pulse answering a held request
// Notes: Stack full is the depth limit or a bench command
`timescale 1ns/1ps
`default_nettype none
module core_model #(
  parameter int DEPTH = 8,
  parameter int PC_W = 10
) (
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_req,
  input wire logic [PC_W-1:0] i_vec,
  input wire logic i_take_en,
  input wire logic i_full_cmd,
  input wire logic i_pop,
  output logic o_take,
  output logic o_full,
  output logic [PC_W-1:0] o_last_vec,
  output logic [7:0] o_taken
);
  int depth; // Entries on the return stack

  // Full stack blocks acknowledge until a pop or until the bench command drops
  assign o_full = i_full_cmd || (depth >= DEPTH);

  ////////////////////////////////////////////////////////////
  // Push on take, pop on return
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      o_take <= 1'b0;
      depth <= 0;
      o_last_vec <= '0;
      o_taken <= '0;
    end else begin
      if (o_take && i_req) begin
        // Next PC pushed, vector loaded
        o_last_vec <= i_vec;
        depth <= depth + 1;
        o_taken <= o_taken + 8'h01;
      end else if (i_pop && depth != 0) begin
        // Return pops the saved PC
        depth <= depth - 1;
      end
      // One pulse per request, never while full
      o_take <= i_req && !o_take && i_take_en && !o_full;
    end
  end
endmodule // core_model
`default_nettype wire

/* dv/tb_top.sv */
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Register port and core handshake as handed over
// Notes: Sequences of register calls with expected values
`timescale 1ns/1ps
`default_nettype none
`include "irq_ctrl_regs.svh"
module tb_top;
  import irq_pkg::*;
  logic clk, rstn, pin, take_en, full_cmd, pop, take, full, irq_req, wake;
  reg_req_s rq;
  src_evt_s src;
  logic [7:0] rdata, taken;
  logic [9:0] vec, last_vec;
  src_e irq_src;
  int miscompares = 0;
  int samples_checked = 0;
  localparam logic [9:0] VT[6] = '{`IRQ_VEC_EXT, `IRQ_VEC_TB0, `IRQ_VEC_TB1,
    `IRQ_VEC_SV0, `IRQ_VEC_SV1, `IRQ_VEC_EE};
  localparam logic [7:0] MK[8] = '{8'h03, 8'h7f, 8'hbb, 8'h33, 8'h33, 8'h00, 8'h00, 8'h00};

  mcu_irq_controller mcu_irq_controller_i (.I_CLOCK(clk), .I_RSTN(rstn), .I_EXT_PIN(pin),
    .I_REG(rq), .I_SRC(src), .I_STACK_FULL(full), .I_IRQ_TAKE(take), .O_REG_RDATA(rdata),
    .O_IRQ_REQ(irq_req), .O_IRQ_VECTOR(vec), .O_IRQ_SRC(irq_src), .O_WAKE(wake));
  core_model core_model_i (.i_clock(clk), .i_rstn(rstn), .i_req(irq_req), .i_vec(vec),
    .i_take_en(take_en), .i_full_cmd(full_cmd), .i_pop(pop), .o_take(take), .o_full(full),
    .o_last_vec(last_vec), .o_taken(taken));

  // Clock at 50 MHz
  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("Comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input int a, input int dat);
    @(posedge clk);
    rq <= '{wr: 1'b1, addr: 3'(a), wdata: 8'(dat)};
    @(posedge clk);
    rq.wr <= 1'b0;
  endtask
  task automatic rd(input int a, output logic [7:0] dat);
    @(posedge clk);
    rq.addr <= 3'(a);
    @(posedge clk);
    #1 dat = rdata;
  endtask
  task automatic rdc(input int a, input logic [7:0] exp);
    logic [7:0] dat;
    rd(a, dat);
    chk("register", exp, dat);
  endtask
  task automatic pulse(input src_evt_s s);
    @(posedge clk);
    src <= s;
    @(posedge clk);
    src <= '0;
  endtask
  // Bounded wait for the core to take a request
  task automatic wait_take(input logic [7:0] n0);
    int k;
    for (k = 0; k < 50 && taken === n0; k++) @(posedge clk);
    if (taken === n0) begin
      miscompares++;
      $display("ERROR take expected pulse seen none");
      report_and_stop();
    end
  endtask

  ////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d, pri, n0;
    clk = 1'b0;
    rstn = 1'b0;
    pin = 1'b0;
    rq = '0;
    src = '0;
    take_en = 1'b0;
    full_cmd = 1'b0;
    pop = 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    // Reset values, implemented masks, unmapped places
    for (int a = 0; a < 8; a++) rdc(a, 8'h00);
    for (int a = 0; a < 8; a++) begin
      wr(a, 8'hff);
      rdc(a, MK[a]);
    end
    for (int a = 7; a >= 0; a--) wr(a, 8'h00);
    // Every edge select code against rise and fall
    for (int s = 0; s < 4; s++) begin
      wr(0, s);
      @(posedge clk) pin <= 1'b1;
      repeat (6) @(posedge clk);
      rd(1, d);
      chk("ext_rise", s[0], d[4]);
      wr(1, 8'h00);
      @(posedge clk) pin <= 1'b0;
      repeat (6) @(posedge clk);
      rd(1, d);
      chk("ext_fall", s[1], d[4]);
      wr(1, 8'h00);
    end
    wr(0, 8'h01);
    // Disabled source: flag and wake, no request
    wr(1, 8'h01);
    pulse('{tbase1: 1'b1, default: 1'b0});
    #1 chk("wake", 16'h0001, wake);
    chk("req_disabled", 16'h0000, irq_req);
    @(posedge clk) #1 chk("wake_end", 16'h0000, wake);
    rdc(1, 8'h41);
    // Hardware set against a same-cycle clear
    @(posedge clk);
    rq <= '{wr: 1'b1, addr: 3'h2, wdata: 8'h00};
    src.eeprom_done <= 1'b1;
    @(posedge clk);
    rq.wr <= 1'b0;
    src <= '0;
    rdc(2, 8'h20);
    wr(2, 8'h00);
    wr(1, 8'h00);
    // All sources at once while blocked, then serviced one by one
    wr(3, 8'h03);
    wr(4, 8'h03);
    wr(2, 8'h0b);
    wr(1, 8'h0e);
    take_en <= 1'b1;
    @(posedge clk) pin <= 1'b1;
    pulse('{tbase0: 1'b1, tbase1: 1'b1, eeprom_done: 1'b1, std_cmp_p: 1'b1, per_cmp_a: 1'b1,
      default: 1'b0});
    repeat (6) @(posedge clk);
    #1 chk("req_blocked", 16'h0000, irq_req);
    rdc(1, 8'h7e);
    rdc(2, 8'hbb);
    pri = 8'h7e;
    for (int i = 0; i < 6; i++) begin
      n0 = taken;
      wr(1, pri | 8'h01);
      #1 chk("req_offered", 16'h0001, irq_req);
      chk("source", 16'(i), irq_src);
      wait_take(n0);
      chk("vector", VT[i], last_vec);
      @(posedge clk) pop <= 1'b1;
      @(posedge clk) pop <= 1'b0;
      if (i < 3) pri[4 + i] = 1'b0;
      rdc(1, pri);
    end
    rdc(2, 8'h0b);
    rdc(3, 8'h13);
    rdc(4, 8'h23);
    // Full stack holds off an enabled request
    @(posedge clk) full_cmd <= 1'b1;
    wr(1, 8'h05);
    pulse('{tbase0: 1'b1, default: 1'b0});
    repeat (5) @(posedge clk);
    #1 chk("req_full", 16'h0000, irq_req);
    n0 = taken;
    @(posedge clk) full_cmd <= 1'b0;
    wait_take(n0);
    chk("vector_after_full", VT[1], last_vec);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
